// *** sec_port.sv ***
// Serial EEPROM command decoder, storage array and self-timed program engine
`timescale 1ns/1ps
// What this block does
// RULE_01 - Instruction is start bit, opcode, address 10/11 bits, data 16/8 bits
// RULE_02 - Opcode 10 read, 11 erase, 01 write, 00 special group
// RULE_03 - Special group: top address bits 11 unlock, 00 lock, 10 clear-all, 01 fill
// RULE_04 - Serial input sampled on every rising serial clock edge
// RULE_05 - Serial output high impedance except read data or busy status
// RULE_06 - Status shows low while programming, high when ready
// RULE_07 - A one clocked in during status floats output at next falling edge
// RULE_08 - Program-type commands need program gate high; lock commands ignore it
// RULE_09 - Read outputs one dummy zero then the word, MSB first
// RULE_10 - Read data bits change on rising serial clock edges
// RULE_11 - Held select continues reading next words, wrapping to zero
// RULE_12 - Write starts self-timed cycle at select falling edge
// RULE_13 - Program cycle runs on its own and ends within cycle time
// RULE_14 - Every write clears the location itself first
// RULE_15 - Erase sets the addressed location to all ones at deselect
// RULE_16 - Powers up locked; unlock and lock commands change it
// RULE_17 - Reads work whatever the lock state
// RULE_18 - Clear-all sets the whole array to ones, status as usual
// RULE_19 - Width strap high or open gives 16-bit words, low 8-bit
// RULE_20 - Fill-all writes its word into every location at deselect
// RULE_21 - Deselect abandons partial instructions; wait for new start bit
module sec_port #(
  parameter int PROG_CYC = sec_pkg::PROG_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_chip_select_pin,
  input wire logic i_serial_clock_pin,
  input wire logic i_serial_in_pin,
  input wire logic i_width_strap_pin,
  input wire logic i_program_gate_pin,
  output logic o_serial_out,
  output logic o_serial_out_oe,
  output logic o_busy
);
  localparam int BW = $clog2(PROG_CYC + 1);

  logic [4:0] s1;
  logic [4:0] s2;
  logic [4:0] s3;
  logic [4:0] pin;
  logic [4:0] pin_q;
  logic cs, di, x16;
  logic cs_rise, cs_fall, sk_rise, sk_fall;
  sec_pkg::sec_state_e st;
  logic [4:0] cnt;
  logic [1:0] opc;
  logic [10:0] adr;
  logic [10:0] nadr;
  logic [15:0] dat;
  logic [1:0] kind;
  logic [1:0] sub;
  logic pend;
  logic adr_done, rd_go, unlocked, start;
  logic busy, sweep;
  logic [BW-1:0] bcnt;
  logic [1:0] pkind;
  logic [15:0] wdat;
  logic [9:0] widx;
  logic lane, ex16, all_op;
  logic [15:0] wv;
  logic we_hi, we_lo;
  logic [7:0] mem_hi [sec_pkg::WORDS];
  logic [7:0] mem_lo [sec_pkg::WORDS];
  logic fetch_on;
  logic [10:0] rd_addr;
  logic [9:0] fw;
  logic [15:0] push_d;
  logic push_v, f_ready, f_valid, pop;
  logic [15:0] f_data;
  logic [15:0] w;
  logic [15:0] osh;
  logic [4:0] ocnt;
  logic shown, arm, spend;

  // Field length for the current organisation
  function automatic logic [4:0] adr_len(input logic w16);
    adr_len = w16 ? sec_pkg::ADR_LEN16 : sec_pkg::ADR_LEN8;
  endfunction

  function automatic logic [4:0] dat_len(input logic w16);
    dat_len = w16 ? sec_pkg::DAT_LEN16 : sec_pkg::DAT_LEN8;
  endfunction

  // Three-stage pin synchronisers; reset to idle pin levels so no false strap change follows
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1 <= sec_pkg::PIN_RST;
      s2 <= sec_pkg::PIN_RST;
      s3 <= sec_pkg::PIN_RST;
    end else begin
      s1 <= {i_program_gate_pin, i_width_strap_pin, i_serial_in_pin,
             i_serial_clock_pin, i_chip_select_pin};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A level counts only once stages two and three agree
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin <= sec_pkg::PIN_RST;
      pin_q <= sec_pkg::PIN_RST;
    end else begin
      pin <= (s2 & s3) | (pin & (s2 | s3));
      pin_q <= pin;
    end
  end

  assign cs = pin[sec_pkg::P_CS];
  assign di = pin[sec_pkg::P_DI];
  // RULE_19 strap picks word width
  assign x16 = pin[sec_pkg::P_ORG];
  assign cs_rise = cs && !pin_q[sec_pkg::P_CS];
  assign cs_fall = !cs && pin_q[sec_pkg::P_CS];
  // RULE_04 rising edge sampling
  assign sk_rise = cs && pin[sec_pkg::P_SK] && !pin_q[sec_pkg::P_SK];
  assign sk_fall = cs && !pin[sec_pkg::P_SK] && pin_q[sec_pkg::P_SK];

  // Address decode on the last address bit
  assign nadr = {adr[9:0], di};
  assign sub = x16 ? nadr[9:8] : nadr[10:9];
  assign adr_done = sk_rise && (st == sec_pkg::ST_ADR) && (cnt == adr_len(x16) - 5'h01);
  // RULE_17 read ignores lock state
  assign rd_go = adr_done && (opc == sec_pkg::OP_READ);

  // Instruction receiver
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= sec_pkg::ST_IDLE;
      cnt <= 5'h00;
      opc <= 2'h0;
      adr <= 11'h000;
      dat <= 16'h0000;
      kind <= sec_pkg::K_WRITE;
      pend <= 1'b0;
    end else if (!cs) begin
      // RULE_21 deselect abandons instruction
      st <= sec_pkg::ST_IDLE;
      cnt <= 5'h00;
      pend <= 1'b0;
    end else if (sk_rise) begin
      case (st)
        sec_pkg::ST_IDLE: begin
          // RULE_01 wait for start bit
          if (di) begin
            st <= sec_pkg::ST_OPC;
            cnt <= 5'h00;
          end
        end
        sec_pkg::ST_OPC: begin
          opc <= {opc[0], di};
          cnt <= (cnt == 5'h01) ? 5'h00 : cnt + 5'h01;
          if (cnt == 5'h01) begin
            st <= sec_pkg::ST_ADR;
          end
        end
        sec_pkg::ST_ADR: begin
          adr <= nadr;
          cnt <= cnt + 5'h01;
          if (adr_done) begin
            cnt <= 5'h00;
            st <= sec_pkg::ST_HOLD;
            // RULE_02 opcode decode
            case (opc)
              sec_pkg::OP_READ: st <= sec_pkg::ST_READ;
              sec_pkg::OP_WRITE: begin
                kind <= sec_pkg::K_WRITE;
                st <= sec_pkg::ST_DATA;
              end
              sec_pkg::OP_ERASE: begin
                kind <= sec_pkg::K_ERASE;
                pend <= !busy;
              end
              default: begin
                // RULE_03 special group by top address bits
                if (sub == sec_pkg::SUB_CLR_ALL) begin
                  kind <= sec_pkg::K_CLR_ALL;
                  pend <= !busy;
                end else if (sub == sec_pkg::SUB_FILL_ALL) begin
                  kind <= sec_pkg::K_FILL_ALL;
                  st <= sec_pkg::ST_DATA;
                end
              end
            endcase
          end
        end
        sec_pkg::ST_DATA: begin
          dat <= {dat[14:0], di};
          cnt <= cnt + 5'h01;
          if (cnt == dat_len(x16) - 5'h01) begin
            st <= sec_pkg::ST_HOLD;
            pend <= !busy;
          end
        end
        default: begin
          cnt <= 5'h00;
        end
      endcase
    end
  end

  // RULE_16 locked from reset, unlock and lock commands
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      unlocked <= 1'b0;
    end else if (adr_done && opc == sec_pkg::OP_SPECIAL) begin
      if (sub == sec_pkg::SUB_UNLOCK) begin
        unlocked <= 1'b1;
      end else if (sub == sec_pkg::SUB_LOCK) begin
        unlocked <= 1'b0;
      end
    end
  end

  // RULE_08 program gate and lock qualify the start
  assign start = cs_fall && pend && unlocked && pin[sec_pkg::P_PE] && !busy;
  assign all_op = (pkind == sec_pkg::K_CLR_ALL) || (pkind == sec_pkg::K_FILL_ALL);

  // Self-timed engine; runs on the core clock, no serial clock needed
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy <= 1'b0;
      sweep <= 1'b0;
      bcnt <= '0;
      pkind <= sec_pkg::K_WRITE;
      wdat <= 16'h0000;
      widx <= 10'h000;
      lane <= 1'b0;
      ex16 <= 1'b1;
    end else if (start) begin
      // RULE_12 deselect edge launches cycle
      busy <= 1'b1;
      sweep <= 1'b1;
      bcnt <= BW'(PROG_CYC - 1);
      pkind <= kind;
      wdat <= dat;
      ex16 <= x16;
      lane <= adr[0];
      widx <= (kind == sec_pkg::K_CLR_ALL || kind == sec_pkg::K_FILL_ALL) ? 10'h000 :
              (x16 ? adr[9:0] : adr[10:1]);
    end else if (busy) begin
      // RULE_13 fixed length cycle
      if (bcnt == '0) begin
        busy <= 1'b0;
      end else begin
        bcnt <= bcnt - {{(BW-1){1'b0}}, 1'b1};
      end
      if (sweep) begin
        if (!all_op || widx == sec_pkg::WORD_MAX) begin
          sweep <= 1'b0;
        end else begin
          widx <= widx + 10'h001;
        end
      end
    end
  end

  // RULE_15 erase and clear-all store ones
  // RULE_14 write overwrites, no prior erase needed
  assign wv = (pkind == sec_pkg::K_ERASE || pkind == sec_pkg::K_CLR_ALL) ? sec_pkg::ERASED :
              (ex16 ? wdat : {wdat[7:0], wdat[7:0]});
  // Byte mode: address bit 0 picks the high byte
  assign we_hi = sweep && (ex16 || all_op || lane);
  assign we_lo = sweep && (ex16 || all_op || !lane);

  // RULE_20 sweep writes every location for the all-commands
  always_ff @(posedge i_clock) begin
    if (we_hi) begin
      mem_hi[widx] <= wv[15:8];
    end
    if (we_lo) begin
      mem_lo[widx] <= wv[7:0];
    end
  end

  // Read prefetch into the FIFO; stalls when the FIFO is full
  assign fw = x16 ? rd_addr[9:0] : rd_addr[10:1];
  assign push_d = x16 ? {mem_hi[fw], mem_lo[fw]} :
                  {8'h00, (rd_addr[0] ? mem_hi[fw] : mem_lo[fw])};
  assign push_v = fetch_on && cs;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fetch_on <= 1'b0;
      rd_addr <= 11'h000;
    end else if (!cs) begin
      fetch_on <= 1'b0;
    end else if (rd_go) begin
      fetch_on <= 1'b1;
      rd_addr <= x16 ? {1'b0, nadr[9:0]} : nadr;
    end else if (push_v && f_ready) begin
      // RULE_11 auto increment with wrap
      rd_addr <= x16 ? {1'b0, rd_addr[9:0] + 10'h001} : rd_addr + 11'h001;
    end
  end

  sec_fifo #(
    .WIDTH(16),
    .DEPTH(4)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_flush(!cs),
    .i_valid(push_v),
    .o_ready(f_ready),
    .i_data(push_d),
    .o_valid(f_valid),
    .i_ready(pop),
    .o_data(f_data)
  );

  // Next word is taken at the rising edge after the previous one's last bit
  assign pop = sk_rise && (st == sec_pkg::ST_READ) && (ocnt == 5'h00) && f_valid;
  assign w = x16 ? f_data : {f_data[7:0], 8'h00};

  // RULE_07 status display and its release
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shown <= 1'b0;
      arm <= 1'b0;
      spend <= 1'b0;
    end else if (cs_fall) begin
      shown <= 1'b0;
      arm <= 1'b0;
      spend <= spend || start;
    end else if (cs_rise) begin
      shown <= spend;
    end else if (sk_rise && shown && di) begin
      arm <= 1'b1;
    end else if (sk_fall && arm) begin
      shown <= 1'b0;
      spend <= 1'b0;
      arm <= 1'b0;
    end
  end

  // Serial output driver, registered
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_serial_out <= 1'b0;
      o_serial_out_oe <= 1'b0;
      osh <= 16'h0000;
      ocnt <= 5'h00;
    end else if (!cs) begin
      // RULE_05 float whenever deselected
      o_serial_out_oe <= 1'b0;
      ocnt <= 5'h00;
    end else if (rd_go) begin
      // RULE_09 dummy zero before data
      o_serial_out_oe <= 1'b1;
      o_serial_out <= 1'b0;
      ocnt <= 5'h00;
    end else if (sk_rise && st == sec_pkg::ST_READ) begin
      // RULE_10 shift on rising edge, MSB first
      if (ocnt == 5'h00) begin
        o_serial_out <= w[15];
        osh <= {w[14:0], 1'b0};
        ocnt <= dat_len(x16) - 5'h01;
      end else begin
        o_serial_out <= osh[15];
        osh <= {osh[14:0], 1'b0};
        ocnt <= ocnt - 5'h01;
      end
    end else if (shown) begin
      // RULE_06 low while busy, high when ready
      o_serial_out_oe <= 1'b1;
      o_serial_out <= !busy;
    end else if (st != sec_pkg::ST_READ) begin
      o_serial_out_oe <= 1'b0;
    end
  end

  assign o_busy = busy;

  property p_hiz;
    @(posedge i_clock) disable iff (!i_rst_n) !cs |=> !o_serial_out_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("output driven while deselected"); // RULE_05

  property p_dummy;
    @(posedge i_clock) disable iff (!i_rst_n) rd_go |=> o_serial_out_oe && !o_serial_out;
  endproperty
  a_dummy: assert property (p_dummy) else $error("no dummy zero after read"); // RULE_09

  property p_busy_low;
    @(posedge i_clock) disable iff (!i_rst_n)
      (cs && shown && busy) |=> (o_serial_out_oe && !o_serial_out);
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("status not low while busy"); // RULE_06

  property p_release;
    @(posedge i_clock) disable iff (!i_rst_n) (sk_fall && arm) |=> !shown ##1 !o_serial_out_oe;
  endproperty
  a_release: assert property (p_release) else $error("status not released"); // RULE_07

  property p_gate;
    @(posedge i_clock) disable iff (!i_rst_n)
      $rose(busy) |-> $past(unlocked) && $past(pin[sec_pkg::P_PE]);
  endproperty
  a_gate: assert property (p_gate) else $error("program cycle without gate or unlock"); // RULE_08

  property p_cycle;
    @(posedge i_clock) disable iff (!i_rst_n) $rose(busy) |-> bcnt == BW'(PROG_CYC - 1);
  endproperty
  a_cycle: assert property (p_cycle) else $error("program cycle length wrong"); // RULE_13

  // Counter end closes the cycle, so it never outlasts the set length
  property p_cycle_end;
    @(posedge i_clock) disable iff (!i_rst_n) (busy && bcnt == '0) |=> !busy;
  endproperty
  a_cycle_end: assert property (p_cycle_end) else $error("program cycle did not end"); // RULE_13

  property p_sweep_end;
    @(posedge i_clock) disable iff (!i_rst_n)
      (sweep && all_op && widx == sec_pkg::WORD_MAX) |=> !sweep;
  endproperty
  a_sweep_end: assert property (p_sweep_end) else $error("array sweep overran"); // RULE_18

  property p_wrap;
    @(posedge i_clock) disable iff (!i_rst_n)
      (push_v && f_ready && !rd_go &&
       rd_addr == (x16 ? {1'b0, sec_pkg::WORD_MAX} : sec_pkg::BYTE_MAX)) |=> rd_addr == 11'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("read address did not wrap"); // RULE_11

  property p_abandon;
    @(posedge i_clock) disable iff (!i_rst_n) !cs |=> st == sec_pkg::ST_IDLE && !pend;
  endproperty
  a_abandon: assert property (p_abandon) else $error("instruction kept across deselect"); // RULE_21
endmodule

// *** sec_pkg.sv ***
// Shared constants and types of the serial EEPROM command port
package sec_pkg;
  // Clock and program cycle timing
  localparam int CLK_KHZ = 25000;
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYC = PROG_TIME_US * CLK_KHZ / 1000;
  // Array geometry and field widths
  localparam int WORDS = 1024;
  localparam logic [9:0] WORD_MAX = 10'h3FF;
  localparam logic [10:0] BYTE_MAX = 11'h7FF;
  localparam logic [4:0] ADR_LEN16 = 5'h0A;
  localparam logic [4:0] ADR_LEN8 = 5'h0B;
  localparam logic [4:0] DAT_LEN16 = 5'h10;
  localparam logic [4:0] DAT_LEN8 = 5'h08;
  localparam logic [15:0] ERASED = 16'hFFFF;
  // Synchronised pin positions and their reset levels
  localparam int P_CS = 0;
  localparam int P_SK = 1;
  localparam int P_DI = 2;
  localparam int P_ORG = 3;
  localparam int P_PE = 4;
  localparam logic [4:0] PIN_RST = 5'h18;
  // Opcodes and special sub-commands
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] SUB_UNLOCK = 2'h3;
  localparam logic [1:0] SUB_LOCK = 2'h0;
  localparam logic [1:0] SUB_CLR_ALL = 2'h2;
  localparam logic [1:0] SUB_FILL_ALL = 2'h1;
  // Kinds of self-timed program cycle
  localparam logic [1:0] K_WRITE = 2'h0;
  localparam logic [1:0] K_ERASE = 2'h1;
  localparam logic [1:0] K_CLR_ALL = 2'h2;
  localparam logic [1:0] K_FILL_ALL = 2'h3;
  // Instruction receiver states
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADR, ST_DATA, ST_HOLD, ST_READ
  } sec_state_e;
endpackage

// *** sec_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides and flush
`timescale 1ns/1ps
module sec_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_flush,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign o_ready = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
  assign o_valid = (wp != rp);
  assign o_data = mem[rp[AW-1:0]];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // Storage, no reset needed since valid guards it
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wp[AW-1:0]] <= i_data;
    end
  end

  // Pointers; flush drops stale prefetched words
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp <= '0;
      rp <= '0;
    end else if (i_flush) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) begin
        wp <= wp + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rp <= rp + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// *** sec_host.sv ***
// Host-side model that drives the select, serial clock and serial data pins
`timescale 1ns/1ps
module sec_host (
  input wire logic i_clock,
  input wire logic i_serial_out,
  input wire logic i_serial_out_oe,
  output logic o_chip_select,
  output logic o_serial_clock,
  output logic o_serial_in
);
  // Idle pins: deselected, serial clock parked low between frames
  initial begin
    o_chip_select = 1'b0;
    o_serial_clock = 1'b0;
    o_serial_in = 1'b0;
  end

  // Raise select, leaving setup time before the first clock rise
  task automatic select_dev();
    o_chip_select <= 1'b1;
    repeat (2) @(posedge i_clock);
  endtask

  // bit set up before rise
  // One 320 ns serial clock: data set, rise, fall, then sample the settled answer;
  // the port answers about five core clocks after a rise, too late for the high half
  task automatic bit_cyc(input logic b, output logic [1:0] r);
    o_serial_in <= b;
    repeat (2) @(posedge i_clock);
    o_serial_clock <= 1'b1;
    repeat (4) @(posedge i_clock);
    o_serial_clock <= 1'b0;
    @(posedge i_clock);
    @(negedge i_clock);
    // Undriven line has no pull, so it shows the inverse of the stale value
    r = {i_serial_out_oe, i_serial_out_oe ? i_serial_out : !i_serial_out};
    @(posedge i_clock);
  endtask

  // deselect past minimum
  // Deselect well past the minimum low time; data line toggled, not held
  task automatic deselect();
    o_chip_select <= 1'b0;
    o_serial_in <= ~o_serial_in;
    repeat (8) @(posedge i_clock);
  endtask
endmodule

// *** tb.sv ***
// Self-checking bench for the serial EEPROM command port
`timescale 1ns/1ps
module tb;
  // Short program cycle; still longer than the 1024-word sweep
  localparam int PC = 1200;
  localparam int LIMIT = 40000;
  typedef struct packed {
    logic [10:0] adr;
    logic [15:0] dat;
  } sec_row_s;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_width_strap_pin = 1'b1;
  logic i_program_gate_pin = 1'b1;
  logic cs_pin;
  logic sk_pin;
  logic di_pin;
  logic o_serial_out;
  logic o_serial_out_oe;
  logic o_busy;
  logic [1:0] r;
  logic [15:0] got [2];
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  // Ordinary cases: a word written, then read back; 0x155 rewritten over zeros
  sec_row_s rows [5] = '{'{11'h000, 16'h1234}, '{11'h3FF, 16'hA5C3},
    '{11'h155, 16'h0000}, '{11'h155, 16'h8001}, '{11'h2AA, 16'hFFFF}};

  always #20 i_clock = ~i_clock;

  sec_port #(.PROG_CYC(PC)) sec_port_inst (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_chip_select_pin(cs_pin),
    .i_serial_clock_pin(sk_pin),
    .i_serial_in_pin(di_pin),
    .i_width_strap_pin(i_width_strap_pin),
    .i_program_gate_pin(i_program_gate_pin),
    .o_serial_out(o_serial_out),
    .o_serial_out_oe(o_serial_out_oe),
    .o_busy(o_busy)
  );

  sec_host sec_host_inst (
    .i_clock(i_clock),
    .i_serial_out(o_serial_out),
    .i_serial_out_oe(o_serial_out_oe),
    .o_chip_select(cs_pin),
    .o_serial_clock(sk_pin),
    .o_serial_in(di_pin)
  );

  // Hang guard, well above the expected run length
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      $display("unexpected at %0t: run did not finish", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] g, input logic [15:0] e, input string what);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  // Special command address: sub-command in the two top address bits
  function automatic logic [10:0] sub_adr(input logic [1:0] s);
    return i_width_strap_pin ? {1'b0, s, 8'h00} : {s, 9'h000};
  endfunction

  // Start bit, opcode, address, optional data, all MSB first; select left high
  task automatic instr(input logic [1:0] op, input logic [10:0] a, input logic [15:0] d,
                       input bit hd);
    int al;
    int dl;
    al = i_width_strap_pin ? 10 : 11;
    dl = i_width_strap_pin ? 16 : 8;
    sec_host_inst.select_dev();
    sec_host_inst.bit_cyc(1'b1, r);
    for (int i = 1; i >= 0; i--) sec_host_inst.bit_cyc(op[i], r);
    for (int i = al - 1; i >= 0; i--) sec_host_inst.bit_cyc(a[i], r);
    if (hd) for (int i = dl - 1; i >= 0; i--) sec_host_inst.bit_cyc(d[i], r);
  endtask

  task automatic special(input logic [1:0] s);
    instr(sec_pkg::OP_SPECIAL, sub_adr(s), 16'h0000, 1'b0); // sub-command
    sec_host_inst.deselect();
  endtask

  // Program-type instruction; when it should run, poll status and release it
  task automatic prog(input logic [1:0] op, input logic [10:0] a, input logic [15:0] d,
                      input bit hd, input logic runs);
    int n;
    n = 0;
    instr(op, a, d, hd); // framing
    sec_host_inst.deselect();
    @(negedge i_clock);
    check({15'h0000, o_busy}, {15'h0000, runs}, "busy after deselect"); // start
    @(posedge i_clock);
    if (runs) begin
      sec_host_inst.select_dev();
      repeat (6) @(posedge i_clock);
      @(negedge i_clock);
      check({14'h0, o_serial_out_oe, o_serial_out}, 16'h0002, "busy status"); // low
      while (n < PC) begin
        @(negedge i_clock);
        if (o_busy !== 1'b1) break;
        n++;
      end
      check({15'h0000, o_busy}, 16'h0000, "cycle overran"); // bounded
      repeat (4) @(negedge i_clock);
      check({14'h0, o_serial_out_oe, o_serial_out}, 16'h0003, "ready status"); // high
      @(posedge i_clock);
      sec_host_inst.bit_cyc(1'b1, r);
      check({14'h0, r}, 16'h0003, "status before fall"); // still driven
      repeat (8) @(negedge i_clock);
      check({15'h0000, o_serial_out_oe}, 16'h0000, "status released"); // float
      @(posedge i_clock);
      sec_host_inst.deselect(); // abandon partial
    end
  endtask

  // Read nw words from a, checking the dummy zero and the float after deselect
  task automatic rd(input logic [10:0] a, input int nw);
    int dl;
    dl = i_width_strap_pin ? 16 : 8;
    instr(sec_pkg::OP_READ, a, 16'h0000, 1'b0);
    check({14'h0, r}, 16'h0002, "dummy bit"); // dummy zero
    for (int w = 0; w < nw; w++) begin
      got[w] = 16'h0000;
      for (int i = dl - 1; i >= 0; i--) begin
        sec_host_inst.bit_cyc(1'b0, r);
        got[w][i] = r[0];
      end
    end
    sec_host_inst.deselect();
    @(negedge i_clock);
    check({15'h0000, o_serial_out_oe}, 16'h0000, "float after read"); // high-z
    @(posedge i_clock);
  endtask

  initial begin
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    check({14'h0, o_serial_out_oe, o_busy}, 16'h0000, "idle in reset"); // idle
    @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (8) @(posedge i_clock);
    // Locked at power-up, then unlocked and cleared
    prog(sec_pkg::OP_SPECIAL, sub_adr(sec_pkg::SUB_CLR_ALL), 16'h0, 1'b0, 1'b0); // lock
    special(sec_pkg::SUB_UNLOCK);
    prog(sec_pkg::OP_SPECIAL, sub_adr(sec_pkg::SUB_CLR_ALL), 16'h0, 1'b0, 1'b1); // run
    rd(11'h2AA, 1);
    check(got[0], sec_pkg::ERASED, "cleared word"); // all ones
    // Row loop: write then read back
    foreach (rows[k]) begin
      prog(sec_pkg::OP_WRITE, rows[k].adr, rows[k].dat, 1'b1, 1'b1); // write
      rd(rows[k].adr, 1);
      check(got[0], rows[k].dat, "word read back"); // auto-clear
    end
    rd(11'h3FF, 2);
    check(got[0], 16'hA5C3, "last word"); // sequential
    check(got[1], 16'h1234, "wrap to zero"); // wrap
    // Gate low refuses a write; lock taken whatever the gate
    i_program_gate_pin <= 1'b0;
    prog(sec_pkg::OP_WRITE, 11'h000, 16'hBEEF, 1'b1, 1'b0); // gate low
    special(sec_pkg::SUB_LOCK); // gate ignored
    i_program_gate_pin <= 1'b1;
    prog(sec_pkg::OP_ERASE, 11'h000, 16'h0, 1'b0, 1'b0); // relocked
    rd(11'h000, 1);
    check(got[0], 16'h1234, "read while locked"); // reads work
    special(sec_pkg::SUB_UNLOCK);
    prog(sec_pkg::OP_ERASE, 11'h3FF, 16'h0, 1'b0, 1'b1); // erase
    rd(11'h3FF, 1);
    check(got[0], sec_pkg::ERASED, "erased word"); // all ones
    prog(sec_pkg::OP_SPECIAL, sub_adr(sec_pkg::SUB_FILL_ALL), 16'h5AC3, 1'b1, 1'b1);
    rd(11'h155, 1);
    check(got[0], 16'h5AC3, "filled word"); // word 0x155 of the fill
    // Byte organisation: strap low, byte address 1 is the high byte of word 0
    i_width_strap_pin <= 1'b0;
    repeat (8) @(posedge i_clock);
    prog(sec_pkg::OP_WRITE, 11'h001, 16'h003C, 1'b1, 1'b1); // byte write
    rd(11'h000, 2);
    check(got[0], 16'h00C3, "low byte"); // byte read
    check(got[1], 16'h003C, "written byte"); // byte lane
    complete_run();
  end
endmodule
